// ---- core/ssup_pkg.sv ----
// constants and types of the supply reset supervisor
`default_nettype none

package ssup_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // time base
  localparam int unsigned CLK_FREQ_MHZ = 125;
  localparam int unsigned CNT_W        = 32;

  ////////////////////////////////////////////////////////////////////////////////
  // release timeouts, least times in microseconds, rounded up to whole cycles
  localparam int unsigned TIMEOUT_CHOICE_SHORT_US = 10000;
  localparam int unsigned TIMEOUT_CHOICE_LONG_US  = 40000;
  localparam int unsigned TIMEOUT_CHOICE_SHORT_CYC = TIMEOUT_CHOICE_SHORT_US * CLK_FREQ_MHZ;
  localparam int unsigned TIMEOUT_CHOICE_LONG_CYC  = TIMEOUT_CHOICE_LONG_US * CLK_FREQ_MHZ;

  ////////////////////////////////////////////////////////////////////////////////
  // reset values of the input synchronisers (fault side on supply)
  localparam logic [2:0] SUPPLY_SYNC_RST = 3'h7;
  localparam logic [2:0] MANUAL_SYNC_RST = 3'h7;
  localparam logic [2:0] SELECT_SYNC_RST = 3'h0;
  localparam logic [CNT_W-1:0] CNT_RST   = 32'h0000_0000;

  typedef enum logic [1:0] {
    SSUP_FAULT,
    SSUP_HOLD,
    SSUP_RUN
  } ssup_state_t;

endpackage : ssup_pkg

`default_nettype wire

// ---- core/ssup_top.sv ----
// supply reset supervisor: fault detection, release timeout, reset output
`default_nettype none

// Functional notes
// - reset asserts as soon as the synchronised supply indication shows an undervoltage.
// - without a manual input, reset holds for the full timeout after the supply recovers.
// - a low manual reset input holds reset, and a timeout follows its return high.
// - the release timeout starts only when the supply is good and, where a manual input is fitted, that input is high.
// - a low timeout select gives the short timeout, a high one the long timeout.
// - the active-high variant drives reset high under faults and low after the timeout.
module ssup_top
  import ssup_pkg::*;
#(
  parameter bit          HAS_MANUAL  = 1'b1,
  parameter bit          ACTIVE_HIGH = 1'b0,
  parameter int unsigned SHORT_CYC   = TIMEOUT_CHOICE_SHORT_CYC,
  parameter int unsigned LONG_CYC    = TIMEOUT_CHOICE_LONG_CYC
) (
  input  wire logic mclk_i,
  input  wire logic sys_rst_i,
  input  wire logic supply_low_i,
  input  wire logic manual_reset_n_i,
  input  wire logic timeout_select_i,
  output var  logic reset_o,
  output var  logic reset_asserted_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // synchronisers: a level counts once stages two and three agree
  logic [2:0]       supply_sync_q;
  logic [2:0]       manual_sync_q;
  logic [2:0]       select_sync_q;
  logic             supply_low_q;
  logic             manual_n_q;
  logic             select_q;

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      supply_sync_q <= SUPPLY_SYNC_RST;
      manual_sync_q <= MANUAL_SYNC_RST;
      select_sync_q <= SELECT_SYNC_RST;
      supply_low_q  <= SUPPLY_SYNC_RST[2];
      manual_n_q    <= MANUAL_SYNC_RST[2];
      select_q      <= SELECT_SYNC_RST[2];
    end else begin
      supply_sync_q <= {supply_sync_q[1:0], supply_low_i};
      manual_sync_q <= {manual_sync_q[1:0], manual_reset_n_i};
      select_sync_q <= {select_sync_q[1:0], timeout_select_i};
      if (supply_sync_q[1] == supply_sync_q[2]) begin
        supply_low_q <= supply_sync_q[2];
      end
      if (manual_sync_q[1] == manual_sync_q[2]) begin
        manual_n_q <= manual_sync_q[2];
      end
      if (select_sync_q[1] == select_sync_q[2]) begin
        select_q <= select_sync_q[2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // fault decode and timeout selection
  ssup_state_t      state_q;
  ssup_state_t      state_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  wire logic        manual_fault_w;
  wire logic        fault_w;
  wire logic [CNT_W-1:0] limit_w;
  wire logic        done_w;
  wire logic        asserted_d;

  assign manual_fault_w = HAS_MANUAL & ~manual_n_q;
  assign fault_w        = supply_low_q | manual_fault_w;
  function automatic logic [CNT_W-1:0] timeout_limit(input logic long_sel);
    timeout_limit = long_sel ? CNT_W'(LONG_CYC - 1) : CNT_W'(SHORT_CYC - 1);
  endfunction : timeout_limit

  // the select strap is read live; a change mid-hold alters that hold's length
  assign limit_w        = timeout_limit(select_q);
  assign done_w         = (cnt_q >= limit_w);
  assign asserted_d     = (state_d != SSUP_RUN);

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    unique case (state_q)
      SSUP_FAULT: begin
        cnt_d = CNT_RST;
        if (!fault_w) begin
          state_d = SSUP_HOLD;
        end
      end
      SSUP_HOLD: begin
        if (fault_w) begin
          state_d = SSUP_FAULT;
          cnt_d   = CNT_RST;
        end else if (done_w) begin
          state_d = SSUP_RUN;
        end else begin
          cnt_d = cnt_q + CNT_W'(1);
        end
      end
      SSUP_RUN: begin
        cnt_d = CNT_RST;
        if (fault_w) begin
          state_d = SSUP_FAULT;
        end
      end
      default: begin
        state_d = SSUP_FAULT;
        cnt_d   = CNT_RST;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state and output flops; output follows next state to save a cycle
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      state_q          <= SSUP_FAULT;
      cnt_q            <= CNT_RST;
      reset_o          <= ACTIVE_HIGH;
      reset_asserted_o <= 1'b1;
    end else begin
      state_q          <= state_d;
      cnt_q            <= cnt_d;
      reset_o          <= ACTIVE_HIGH ? asserted_d : ~asserted_d;
      reset_asserted_o <= asserted_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  supply_fault_a: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    supply_low_q |=> reset_asserted_o)
    else $error("supply fault did not assert reset");

  hold_full_a: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    (state_q == SSUP_HOLD && !fault_w && cnt_q < limit_w) |=> reset_asserted_o)
    else $error("reset released before timeout ended");

  manual_hold_a: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    (HAS_MANUAL && !manual_n_q) |=> reset_asserted_o)
    else $error("manual input low did not hold reset");

  release_cause_a: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    $fell(reset_asserted_o) |-> $past(!supply_low_q && !manual_fault_w))
    else $error("reset released while a fault was present");

  select_len_a: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    $fell(reset_asserted_o) |->
      $past(cnt_q) == timeout_limit($past(select_q)))
    else $error("timeout length does not match select input");

  polarity_a: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    reset_o == (ACTIVE_HIGH ? reset_asserted_o : !reset_asserted_o))
    else $error("reset output polarity wrong");

  restart_a: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    fault_w |=> (cnt_q == CNT_RST && state_q == SSUP_FAULT))
    else $error("timeout counter not restarted by fault");

  hold_count_a: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    (state_q == SSUP_HOLD && !fault_w && !done_w) |=> cnt_q == $past(cnt_q) + CNT_W'(1))
    else $error("timeout counter failed to advance");

  assert_cause_a: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    $rose(reset_asserted_o) |-> $past(fault_w))
    else $error("reset asserted with no fault present");

  state_out_a: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    reset_asserted_o == (state_q != SSUP_RUN))
    else $error("reset status disagrees with state");

  release_keep_a: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    (state_q == SSUP_RUN && !fault_w) |=> !reset_asserted_o)
    else $error("reset reasserted with no fault present");

  no_manual_a: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    (!HAS_MANUAL && !supply_low_q) |-> !fault_w)
    else $error("manual input counted on a variant without one");

  hold_start_a: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    (state_q == SSUP_FAULT && !fault_w) |=> (state_q == SSUP_HOLD && cnt_q == CNT_RST))
    else $error("timeout did not start once all faults cleared");

  fault_clear_a: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    (state_q == SSUP_FAULT) |-> (cnt_q == CNT_RST))
    else $error("timeout counter not cleared during fault");

  // a level only moves once stages two and three agree, so one-cycle glitches drop out
  supply_filter_a: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    !$stable(supply_low_q) |-> $past(supply_sync_q[1] == supply_sync_q[2]))
    else $error("supply level taken before two stages agreed");

  manual_filter_a: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    !$stable(manual_n_q) |-> $past(manual_sync_q[1] == manual_sync_q[2]))
    else $error("manual level taken before two stages agreed");

  select_filter_a: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    !$stable(select_q) |-> $past(select_sync_q[1] == select_sync_q[2]))
    else $error("select level taken before two stages agreed");

endmodule : ssup_top

`default_nettype wire

// ---- verification/ssup_sys_model.sv ----
// system-side model that decodes the reset level it receives
`default_nettype none

module ssup_sys_model (
  input  wire logic reset_low_i,
  input  wire logic reset_high_i,
  output logic      held_low_o,
  output logic      held_high_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // one model watches both variants, so no polarity strap is needed
  assign held_low_o  = !reset_low_i;
  assign held_high_o = reset_high_i;
endmodule : ssup_sys_model

`default_nettype wire

// ---- verification/testbench.sv ----
// self-checking bench of the supply reset supervisor
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic      mclk_i = 1'b0;
  logic      sys_rst_i = 1'b1;
  logic      sup = 1'b1;
  logic      man = 1'b1;
  logic      sel = 1'b0;
  wire logic rst_a, rst_b, asrt_a, asrt_b, held_a, held_b;
  int        fails = 0;
  int        checks_done = 0;
  int        cyc = 0;
  // short hold lengths keep the run brief
  localparam int unsigned SIM_SHORT = 20;
  localparam int unsigned SIM_LONG  = 50;

  ssup_top #(.SHORT_CYC(SIM_SHORT), .LONG_CYC(SIM_LONG)) i_ssup_top (.mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i), .supply_low_i(sup), .manual_reset_n_i(man),
    .timeout_select_i(sel), .reset_o(rst_a), .reset_asserted_o(asrt_a));
  // second variant: no manual input, active-high output
  ssup_top #(.HAS_MANUAL(1'b0), .ACTIVE_HIGH(1'b1),
    .SHORT_CYC(SIM_SHORT), .LONG_CYC(SIM_LONG))
    i_ssup_top_b (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .supply_low_i(sup),
    .manual_reset_n_i(man), .timeout_select_i(sel), .reset_o(rst_b),
    .reset_asserted_o(asrt_b));
  ssup_sys_model i_ssup_sys_model (.reset_low_i(rst_a), .reset_high_i(rst_b),
    .held_low_o(held_a), .held_high_o(held_b));

  initial begin
    forever #4 mclk_i = ~mclk_i;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task step(input int k);
    repeat (k) @(posedge mclk_i);
    #1;
  endtask : step
  task chk(input logic seen, input logic exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %0t reset level wrong", $time);
    end
  endtask : chk
  task ex(input logic a, input logic b);
    chk(held_a, a);
    chk(asrt_a, a);
    chk(held_b, b);
    chk(asrt_b, b);
  endtask : ex
  // pins change on the edge, as a board pin seen by the flops
  task drive(input logic s, input logic m, input logic t);
    @(posedge mclk_i);
    sup <= s;
    man <= m;
    sel <= t;
  endtask : drive
  // clear all faults, then expect release exactly n cycles into the hold
  task rel(input int n, input logic t, input logic b);
    drive(1'b0, 1'b1, t);
    step(n + 4);
    ex(1'b1, b);
    step(1);
    ex(1'b0, 1'b0);
  endtask : rel

  ////////////////////////////////////////////////////////////////////////////////
  task t_fault_long;
    drive(1'b1, 1'b1, 1'b1);
    step(4);
    ex(1'b0, 1'b0);
    step(1);
    ex(1'b1, 1'b1);
    rel(50, 1'b1, 1'b1);
  endtask : t_fault_long
  task t_manual;
    drive(1'b0, 1'b0, 1'b0);
    step(4);
    ex(1'b0, 1'b0);
    step(31);
    ex(1'b1, 1'b0);
    rel(20, 1'b0, 1'b0);
  endtask : t_manual
  // supply good with manual still low must not start the hold; a dip mid-hold restarts it
  task t_both;
    drive(1'b1, 1'b0, 1'b0);
    step(30);
    ex(1'b1, 1'b1);
    drive(1'b0, 1'b0, 1'b0);
    step(30);
    ex(1'b1, 1'b0);
    drive(1'b0, 1'b1, 1'b0);
    step(14);
    drive(1'b1, 1'b1, 1'b0);
    step(5);
    rel(20, 1'b0, 1'b1);
  endtask : t_both
  // mid-run reset: outputs assert, then a full hold follows the release
  task t_reset;
    @(posedge mclk_i);
    sys_rst_i <= 1'b1;
    step(2);
    ex(1'b1, 1'b1);
    @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    step(24);
    ex(1'b1, 1'b1);
    step(1);
    ex(1'b0, 1'b0);
  endtask : t_reset

  task tally_and_finish;
    if (fails == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (5) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    rel(20, 1'b0, 1'b1);
    t_fault_long();
    t_manual();
    t_both();
    t_reset();
    tally_and_finish();
  end
endmodule : testbench

`default_nettype wire
